// File: design/mdf_pkg.sv
// Package of the motor diagnostic flag bank: register map, field layouts,
// reset values and flag types shared by the bank and its synchroniser.
// Assumes a 32-bit AXI4-Lite register bus and a single 200 MHz clock.
package mdf_pkg;

	// Bus geometry
	localparam int AXI_AW = 8;
	localparam int DW     = 32;
	localparam int STRB_W = DW / 8;

	// Register byte offsets
	localparam logic [AXI_AW-1:0] OFF_CMD      = 8'h00;
	localparam logic [AXI_AW-1:0] OFF_RESP_A   = 8'h04;
	localparam logic [AXI_AW-1:0] OFF_RESP_B   = 8'h08;
	localparam logic [AXI_AW-1:0] OFF_RESP_S   = 8'h0C;
	localparam logic [AXI_AW-1:0] OFF_LIVE     = 8'h10;
	localparam logic [AXI_AW-1:0] OFF_IRQ_STAT = 8'h14;
	localparam logic [AXI_AW-1:0] OFF_IRQ_MASK = 8'h18;
	localparam logic [AXI_AW-1:0] OFF_SAFE_POS = 8'h1C;
	localparam logic [AXI_AW-1:0] OFF_BEMF_CFG = 8'h20;

	// Command register bit positions
	localparam int CMD_FULL_A = 0;
	localparam int CMD_FULL_B = 1;
	localparam int CMD_SHORT  = 2;
	localparam int CMD_POS    = 3;

	// Back-EMF configuration fields
	localparam int THR_W     = 4;
	localparam int FLOOR_LSB = 0;
	localparam int BAND_LSB  = 8;
	localparam int BEMF_W    = 8;
	localparam int BW1       = BEMF_W + 1;

	// Safe target position
	localparam int SAFE_W = 11;
	localparam logic [SAFE_W-1:0] SAFE_RESERVED = 11'h400;
	localparam logic [SAFE_W-1:0] SAFE_RST      = SAFE_RESERVED;

	localparam logic [1:0] THERM_NORMAL = 2'h0;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	// Raw conditions from the analog side, in pin order
	typedef struct packed {
		logic pump;
		logic ocx;
		logic ocy;
		logic openx;
		logic openy;
		logic supply_low;
		logic tsd;
		logic tw;
		logic step_lost;
	} mdf_cond_s;
	localparam int COND_W = $bits(mdf_cond_s);

	// Live flag set
	typedef struct packed {
		logic       pump_fail;
		logic       elec_defect;
		logic       elec_summary;
		logic       coil_x_overcurrent;
		logic       coil_y_overcurrent;
		logic       missed_step_flag;
		logic       bemf_above_band;
		logic       bemf_below_band;
		logic       bemf_below_floor;
		logic       thermal_trip;
		logic       thermal_warn;
		logic       supply_low_stop;
		logic       logic_supply_restart;
		logic [2:0] motion;
		logic [1:0] thermal_level;
	} mdf_flags_s;
	localparam mdf_flags_s FLAGS_RST = '{missed_step_flag: 1'h1,
		logic_supply_restart: 1'h1, default: '0};

	// Snapshot answered to a full status read of the first kind
	typedef struct packed {
		logic       pump_fail;
		logic       elec_defect;
		logic [2:0] motion;
		logic       coil_x_overcurrent;
		logic       coil_y_overcurrent;
		logic       missed_step_flag;
		logic [1:0] thermal_level;
		logic       thermal_trip;
		logic       thermal_warn;
		logic       supply_low_stop;
		logic       logic_supply_restart;
	} mdf_resp_a_s;

	// Snapshot answered to a full status read of the second kind
	typedef struct packed {
		logic bemf_above_band;
		logic bemf_below_band;
		logic bemf_below_floor;
	} mdf_resp_b_s;

	// Snapshot answered to a short status or position read
	typedef struct packed {
		logic       logic_supply_restart;
		logic       elec_summary;
		logic [2:0] motion;
		logic [1:0] thermal_level;
	} mdf_resp_s_s;

	// Interrupt events, one sticky bit each
	typedef struct packed {
		logic pump;
		logic eldef;
		logic ocx;
		logic ocy;
		logic step;
		logic tsd;
		logic tw;
		logic uv;
		logic bemf;
	} mdf_ev_s;
	localparam int EV_W = $bits(mdf_ev_s);

endpackage

// File: design/mdf_cond_if.sv
// Carrier for the analog condition levels between bank and synchroniser.
// Assumes both ends sit in the clk domain of the flag bank.
`timescale 1ns/10ps
`default_nettype none
interface mdf_cond_if;
	import mdf_pkg::*;
	mdf_cond_s raw;
	mdf_cond_s sync;
	modport syncer (input raw, output sync);
	modport user (output raw, input sync);
endinterface
`default_nettype wire

// File: design/mdf_sync.sv
// Two-stage synchroniser for the asynchronous condition levels.
// Assumes levels are slow compared with the 5 ns clock.
`timescale 1ns/10ps
`default_nettype none
module mdf_sync
	import mdf_pkg::*;
(
	input  wire logic clk,       // 200 MHz clock
	input  wire logic rst_b,     // Async reset, active low
	input  wire logic ce,        // Clock enable
	mdf_cond_if.syncer cif       // Raw in, synchronised out
);
	typedef struct packed {
		mdf_cond_s s1;
		mdf_cond_s s2;
	} mdf_sync_st_s;

	mdf_sync_st_s q;
	mdf_sync_st_s d;

	// First stage feeds only the second stage
	always_comb begin
		d    = q;
		d.s1 = cif.raw;
		d.s2 = q.s1;
	end

	// State register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign cif.sync = q.s2;
endmodule
`default_nettype wire

// File: design/mdf_flag_bank.sv
// Diagnostic and status flag bank of a stepper motor driver, with an
// AXI4-Lite slave, read-to-clear status snapshots and an interrupt.
// Assumes motion, thermal and back-EMF inputs come from clk-domain logic.
//
// Summary of operation
// RULE1: pump_fail sticks until full read A
// RULE2: elec_defect ORs coil and pump faults
// RULE3: elec_summary ORs supply and defect flags
// RULE4: motion field: direction bit plus phase
// RULE5: per-coil overcurrent sticks until full read A
// RULE6: safe target invalid on reserved pattern
// RULE7: missed step flag, reset one, sticky
// RULE8: back-EMF above reference plus band
// RULE9: back-EMF below reference minus band
// RULE10: back-EMF below floor level
// RULE11: two-bit thermal level reported
// RULE12: thermal flags clear only when normal
// RULE13: supply low stop flag sticky
// RULE14: restart flag set at power-up
// RULE15: capture first, set beats clear
`timescale 1ns/10ps
`default_nettype none
module mdf_flag_bank
	import mdf_pkg::*;
(
	input  wire logic              clk,            // 200 MHz clock
	input  wire logic              rst_b,          // Async reset, low
	input  wire logic              ce,             // Clock enable
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,   // Write address
	input  wire logic [2:0]        s_axi_awprot,   // Unused protection
	input  wire logic              s_axi_awvalid,  // Write address valid
	output logic                   s_axi_awready,  // Write address ready
	input  wire logic [DW-1:0]     s_axi_wdata,    // Write data
	input  wire logic [STRB_W-1:0] s_axi_wstrb,    // Byte enables
	input  wire logic              s_axi_wvalid,   // Write data valid
	output logic                   s_axi_wready,   // Write data ready
	output logic [1:0]             s_axi_bresp,    // Write response
	output logic                   s_axi_bvalid,   // Write resp valid
	input  wire logic              s_axi_bready,   // Write resp ready
	input  wire logic [AXI_AW-1:0] s_axi_araddr,   // Read address
	input  wire logic [2:0]        s_axi_arprot,   // Unused protection
	input  wire logic              s_axi_arvalid,  // Read address valid
	output logic                   s_axi_arready,  // Read address ready
	output logic [DW-1:0]          s_axi_rdata,    // Read data
	output logic [1:0]             s_axi_rresp,    // Read response
	output logic                   s_axi_rvalid,   // Read valid
	input  wire logic              s_axi_rready,   // Read ready
	input  wire logic [COND_W-1:0] cond_raw,       // Async conditions
	input  wire logic [2:0]        motion_in,      // Motion phase
	input  wire logic [1:0]        thermal_in,     // Thermal level
	input  wire logic [BEMF_W-1:0] bemf_meas,      // Measured back-EMF
	input  wire logic [BEMF_W-1:0] bemf_ref,       // Reference back-EMF
	output logic                   elec_summary,   // Electrical summary
	output logic                   safe_target_valid, // Safe pos usable
	output logic                   irq             // Level interrupt
);
	typedef struct packed {
		logic              aw_got;
		logic              w_got;
		logic [AXI_AW-1:0] awaddr;
		logic [DW-1:0]     wdata;
		logic [STRB_W-1:0] wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [DW-1:0]     rdata;
		mdf_flags_s        fl;
		mdf_resp_a_s       ra;
		mdf_resp_b_s       rb;
		mdf_resp_s_s       rs;
		mdf_ev_s           stat;
		mdf_ev_s           mask;
		logic [SAFE_W-1:0] safe_pos;
		logic              safe_valid;
		logic [THR_W-1:0]  floor_lvl;
		logic [THR_W-1:0]  band;
		logic              irq;
	} mdf_st_s;

	localparam mdf_st_s ST_RST = '{fl: FLAGS_RST, safe_pos: SAFE_RST,
		default: '0};

	mdf_st_s         q;
	mdf_st_s         d;
	mdf_cond_if      cif ();
	logic            aw_hs;
	logic            w_hs;
	logic            ar_hs;
	logic            wr_go;
	logic [AXI_AW-1:0] wr_addr;
	logic [DW-1:0]   wr_data;
	logic [STRB_W-1:0] wr_strb;
	logic            cmd_a;
	logic            cmd_b;
	logic            cmd_s;
	logic            cmd_p;
	logic            th_clr;
	logic            eld_src;
	logic            hi_hit;
	logic            lo_hit;
	logic            fl_hit;
	mdf_cond_s       c;
	mdf_ev_s         ev;
	mdf_ev_s         w1c;

	// Byte-lane merge of a bus write into a register image
	function automatic logic [DW-1:0] merge(input logic [DW-1:0] o,
		input logic [DW-1:0] n, input logic [STRB_W-1:0] s);
		logic [DW-1:0] r;
		r = o;
		for (int i = 0; i < STRB_W; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Condition levels pass two flops before any use
	assign cif.raw = mdf_cond_s'(cond_raw);
	mdf_sync u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.ce    (ce),
		.cif   (cif)
	);
	assign c = cif.sync;

	// Channel readies; one write and one read outstanding at most
	assign s_axi_awready = ce & ~q.aw_got & ~q.bvalid;
	assign s_axi_wready  = ce & ~q.w_got & ~q.bvalid;
	assign s_axi_arready = ce & ~q.rvalid;
	assign aw_hs = s_axi_awvalid & s_axi_awready;
	assign w_hs  = s_axi_wvalid & s_axi_wready;
	assign ar_hs = s_axi_arvalid & s_axi_arready;
	assign wr_go = (q.aw_got | aw_hs) & (q.w_got | w_hs);
	assign wr_addr = q.aw_got ? q.awaddr : s_axi_awaddr;
	assign wr_data = q.w_got ? q.wdata : s_axi_wdata;
	assign wr_strb = q.w_got ? q.wstrb : s_axi_wstrb;

	// Status read commands issued by a write to the command register
	always_comb begin
		cmd_a = 1'h0;
		cmd_b = 1'h0;
		cmd_s = 1'h0;
		cmd_p = 1'h0;
		if (wr_go && wr_addr == OFF_CMD && wr_strb[0]) begin
			cmd_a = wr_data[CMD_FULL_A];
			cmd_b = wr_data[CMD_FULL_B];
			cmd_s = wr_data[CMD_SHORT];
			cmd_p = wr_data[CMD_POS];
		end
	end

	// Thermal clear needs a normal temperature level
	assign th_clr = cmd_a & (q.fl.thermal_level == THERM_NORMAL); // RULE12
	assign eld_src = c.ocx | c.ocy | c.openx | c.openy | c.pump; // RULE2

	// Back-EMF window comparisons, widened to avoid wrap
	assign hi_hit = BW1'(bemf_meas) > BW1'(bemf_ref) + BW1'(q.band); // RULE8
	assign lo_hit = BW1'(bemf_meas) + BW1'(q.band) < BW1'(bemf_ref); // RULE9
	assign fl_hit = bemf_meas < BEMF_W'(q.floor_lvl); // RULE10

	// Events are fresh sets of flags
	always_comb begin
		ev       = '0;
		ev.pump  = c.pump & ~q.fl.pump_fail;
		ev.eldef = eld_src & ~q.fl.elec_defect;
		ev.ocx   = c.ocx & ~q.fl.coil_x_overcurrent;
		ev.ocy   = c.ocy & ~q.fl.coil_y_overcurrent;
		ev.step  = c.step_lost & ~q.fl.missed_step_flag;
		ev.tsd   = c.tsd & ~q.fl.thermal_trip;
		ev.tw    = c.tw & ~q.fl.thermal_warn;
		ev.uv    = c.supply_low & ~q.fl.supply_low_stop;
		ev.bemf  = (hi_hit & ~q.fl.bemf_above_band)
			| (lo_hit & ~q.fl.bemf_below_band)
			| (fl_hit & ~q.fl.bemf_below_floor);
	end

	// Next state: bus, register writes, flags, snapshots, interrupt
	always_comb begin
		d   = q;
		w1c = '0;
		// Write channel capture and completion
		if (aw_hs) begin
			d.aw_got = 1'h1;
			d.awaddr = s_axi_awaddr;
		end
		if (w_hs) begin
			d.w_got = 1'h1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'h0;
		end
		if (wr_go) begin
			d.aw_got = 1'h0;
			d.w_got  = 1'h0;
			d.bvalid = 1'h1;
			d.bresp  = RESP_OKAY;
			unique case (wr_addr)
				OFF_CMD, OFF_RESP_A, OFF_RESP_B, OFF_RESP_S,
				OFF_LIVE: begin
				end
				OFF_IRQ_STAT: begin
					w1c = mdf_ev_s'(merge('0, wr_data, wr_strb));
				end
				OFF_IRQ_MASK: begin
					d.mask = mdf_ev_s'(merge(DW'(q.mask), wr_data,
						wr_strb));
				end
				OFF_SAFE_POS: begin
					d.safe_pos = SAFE_W'(merge(DW'(q.safe_pos),
						wr_data, wr_strb));
				end
				OFF_BEMF_CFG: begin
					d.floor_lvl = wr_strb[0] ?
						wr_data[FLOOR_LSB +: THR_W] : q.floor_lvl;
					d.band = wr_strb[1] ?
						wr_data[BAND_LSB +: THR_W] : q.band;
				end
				default: begin
					d.bresp = RESP_SLVERR;
				end
			endcase
		end

		// Snapshots take the flags as they stand before clearing
		if (cmd_a) begin // RULE15
			d.ra = '{pump_fail: q.fl.pump_fail,
				elec_defect: q.fl.elec_defect,
				motion: q.fl.motion,
				coil_x_overcurrent: q.fl.coil_x_overcurrent,
				coil_y_overcurrent: q.fl.coil_y_overcurrent,
				missed_step_flag: q.fl.missed_step_flag,
				thermal_level: q.fl.thermal_level,
				thermal_trip: q.fl.thermal_trip,
				thermal_warn: q.fl.thermal_warn,
				supply_low_stop: q.fl.supply_low_stop,
				logic_supply_restart: q.fl.logic_supply_restart};
		end
		if (cmd_b) begin // RULE15
			d.rb = '{bemf_above_band: q.fl.bemf_above_band,
				bemf_below_band: q.fl.bemf_below_band,
				bemf_below_floor: q.fl.bemf_below_floor};
		end
		if (cmd_s || cmd_p) begin // RULE14
			d.rs = '{logic_supply_restart: q.fl.logic_supply_restart,
				elec_summary: q.fl.elec_summary,
				motion: q.fl.motion,
				thermal_level: q.fl.thermal_level};
		end

		// Sticky flags: a present condition beats the clear
		d.fl.pump_fail = (q.fl.pump_fail & ~cmd_a) | c.pump; // RULE1 RULE15
		d.fl.elec_defect = (q.fl.elec_defect & ~cmd_a) | eld_src; // RULE2
		d.fl.coil_x_overcurrent = (q.fl.coil_x_overcurrent & ~cmd_a)
			| c.ocx; // RULE5
		d.fl.coil_y_overcurrent = (q.fl.coil_y_overcurrent & ~cmd_a)
			| c.ocy; // RULE5
		d.fl.missed_step_flag = (q.fl.missed_step_flag & ~cmd_a)
			| c.step_lost; // RULE7
		d.fl.supply_low_stop = (q.fl.supply_low_stop & ~cmd_a)
			| c.supply_low; // RULE13
		d.fl.thermal_trip = (q.fl.thermal_trip & ~th_clr) | c.tsd; // RULE12
		d.fl.thermal_warn = (q.fl.thermal_warn & ~th_clr) | c.tw; // RULE12
		d.fl.logic_supply_restart = q.fl.logic_supply_restart
			& ~(cmd_a | cmd_s); // RULE14

		// Summary of electrical trouble
		d.fl.elec_summary = q.fl.pump_fail | q.fl.supply_low_stop
			| q.fl.elec_defect | q.fl.logic_supply_restart; // RULE3

		// Live reports: motion phase, thermal level, back-EMF
		d.fl.motion = motion_in; // RULE4
		d.fl.thermal_level = thermal_in; // RULE11
		d.fl.bemf_above_band = hi_hit; // RULE8
		d.fl.bemf_below_band = lo_hit; // RULE9
		d.fl.bemf_below_floor = fl_hit; // RULE10

		// Safe target usable unless it holds the reserved pattern
		d.safe_valid = (q.safe_pos != SAFE_RESERVED); // RULE6

		// Interrupt status: new event wins over write-one-to-clear
		d.stat = (q.stat & ~w1c) | ev;
		d.irq  = |(d.stat & d.mask);

		// Read channel
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'h0;
		end
		if (ar_hs) begin
			d.rvalid = 1'h1;
			d.rresp  = RESP_OKAY;
			unique case (s_axi_araddr)
				OFF_CMD:      d.rdata = '0;
				OFF_RESP_A:   d.rdata = DW'(q.ra);
				OFF_RESP_B:   d.rdata = DW'(q.rb);
				OFF_RESP_S:   d.rdata = DW'(q.rs);
				OFF_LIVE:     d.rdata = DW'({q.safe_valid, q.fl});
				OFF_IRQ_STAT: d.rdata = DW'(q.stat);
				OFF_IRQ_MASK: d.rdata = DW'(q.mask);
				OFF_SAFE_POS: d.rdata = DW'(q.safe_pos);
				OFF_BEMF_CFG: begin
					d.rdata = '0;
					d.rdata[FLOOR_LSB +: THR_W] = q.floor_lvl;
					d.rdata[BAND_LSB +: THR_W]  = q.band;
				end
				default: begin
					d.rdata = '0;
					d.rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= ST_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	// Registered outputs
	assign s_axi_bvalid      = q.bvalid;
	assign s_axi_bresp       = q.bresp;
	assign s_axi_rvalid      = q.rvalid;
	assign s_axi_rresp       = q.rresp;
	assign s_axi_rdata       = q.rdata;
	assign elec_summary      = q.fl.elec_summary;
	assign safe_target_valid = q.safe_valid;
	assign irq               = q.irq;
endmodule
`default_nettype wire

// File: bench/mdf_flag_bank_monitor.sv
// Checker of the flag bank: bus answers, summary and safe-target outputs.
// Bound to mdf_flag_bank; sees only its ports, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module mdf_flag_bank_monitor
	import mdf_pkg::*;
(
	input wire logic              clk,               // Clock
	input wire logic              rst_b,             // Reset, low
	input wire logic              ce,                // Clock enable
	input wire logic [AXI_AW-1:0] s_axi_awaddr,      // Write address
	input wire logic              s_axi_awvalid,     // Aw valid
	input wire logic              s_axi_awready,     // Aw ready
	input wire logic [DW-1:0]     s_axi_wdata,       // Write data
	input wire logic [STRB_W-1:0] s_axi_wstrb,       // Byte enables
	input wire logic              s_axi_wvalid,      // W valid
	input wire logic              s_axi_wready,      // W ready
	input wire logic [1:0]        s_axi_bresp,       // Write resp
	input wire logic              s_axi_bvalid,      // B valid
	input wire logic              s_axi_bready,      // B ready
	input wire logic              s_axi_arvalid,     // Ar valid
	input wire logic [AXI_AW-1:0] s_axi_araddr,      // Read address
	input wire logic              s_axi_arready,     // Ar ready
	input wire logic [DW-1:0]     s_axi_rdata,       // Read data
	input wire logic [1:0]        s_axi_rresp,       // Read resp
	input wire logic              s_axi_rvalid,      // R valid
	input wire logic              s_axi_rready,      // R ready
	input wire logic [COND_W-1:0] cond_raw,          // Conditions
	input wire logic              elec_summary,      // Summary flag
	input wire logic              safe_target_valid  // Safe pos usable
);
	logic wr_pair;
	logic safe_wr;

	// Whole write taken at one edge, and its full safe-position form
	assign wr_pair = ce && s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready;
	assign safe_wr = wr_pair && s_axi_awaddr == OFF_SAFE_POS
		&& s_axi_wstrb[1:0] == 2'h3;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	AST_WR_RESP: assert property (wr_pair |=> s_axi_bvalid)
		else $error("write pair not answered next cycle");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	AST_R_ANSWER: assert property (ce && s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read not answered next cycle");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	AST_R_UNMAPPED: assert property (ce && s_axi_arvalid && s_axi_arready
		&& s_axi_araddr > OFF_BEMF_CFG
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
		else $error("unmapped read not refused");
	AST_SUMMARY_BOOT: assert property ($rose(rst_b) |-> ##[0:2] elec_summary)
		else $error("summary not raised after power-up");
	AST_SUMMARY_PUMP: assert property (cond_raw[COND_W-1] [*6] |=> elec_summary)
		else $error("summary low during pump failure");
	AST_SAFE_OFF: assert property (safe_wr
		&& s_axi_wdata[SAFE_W-1:0] == SAFE_RESERVED
		|=> ##1 !safe_target_valid)
		else $error("reserved safe position reported valid");
	AST_SAFE_ON: assert property (safe_wr
		&& s_axi_wdata[SAFE_W-1:0] != SAFE_RESERVED
		|=> ##1 safe_target_valid)
		else $error("safe position reported invalid");
endmodule

bind mdf_flag_bank mdf_flag_bank_monitor mdf_flag_bank_monitor_inst (
	.clk, .rst_b, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_araddr, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .cond_raw, .elec_summary,
	.safe_target_valid);
`default_nettype wire

// File: bench/mdf_axi_master.sv
// AXI4-Lite master model standing in for the host that reads the flags.
// Assumes the bank's clock; one write or one read at a time.
`timescale 1ns/10ps
`default_nettype none
module mdf_axi_master
	import mdf_pkg::*;
(
	input  wire logic              clk,           // Clock
	output logic [AXI_AW-1:0]      s_axi_awaddr,  // Write address
	output logic                   s_axi_awvalid, // Aw valid
	input  wire logic              s_axi_awready, // Aw ready
	output logic [DW-1:0]          s_axi_wdata,   // Write data
	output logic [STRB_W-1:0]      s_axi_wstrb,   // Byte enables
	output logic                   s_axi_wvalid,  // W valid
	input  wire logic              s_axi_wready,  // W ready
	input  wire logic [1:0]        s_axi_bresp,   // Write resp
	input  wire logic              s_axi_bvalid,  // B valid
	output logic                   s_axi_bready,  // B ready
	output logic [AXI_AW-1:0]      s_axi_araddr,  // Read address
	output logic                   s_axi_arvalid, // Ar valid
	input  wire logic              s_axi_arready, // Ar ready
	input  wire logic [DW-1:0]     s_axi_rdata,   // Read data
	input  wire logic [1:0]        s_axi_rresp,   // Read resp
	input  wire logic              s_axi_rvalid,  // R valid
	output logic                   s_axi_rready   // R ready
);
	// Idle bus at time zero
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
	end

	// Write: both channels offered, each released with a changed payload
	task automatic wr(input logic [AXI_AW-1:0] a, input logic [DW-1:0] d,
		input logic [STRB_W-1:0] s, output logic [1:0] r);
		logic ta, tw, ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			@(posedge clk);
			if (ta) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (tw) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
			ad |= ta;
			wd |= tw;
		end while (!(ad && wd));
		do @(negedge clk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		@(posedge clk);
		s_axi_bready <= 1'b0;
	endtask

	// Read: address held until taken, ready held until data arrives
	task automatic rd(input logic [AXI_AW-1:0] a, output logic [DW-1:0] d,
		output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(negedge clk); while (!s_axi_arready);
		@(posedge clk);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		do @(negedge clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge clk);
		s_axi_rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: bench/tb_mdf_flag_bank.sv
// Self-checking bench of the flag bank: conditions, status commands and
// registers compared against an integer model of the sticky flags.
// Assumes the master model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb_mdf_flag_bank;
	import mdf_pkg::*;
	logic              clk, rst_b, ce;
	logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic              s_axi_rready, elec_summary, safe_target_valid, irq;
	logic [DW-1:0]     s_axi_wdata, s_axi_rdata;
	logic [STRB_W-1:0] s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp, thermal_in;
	logic [COND_W-1:0] cond_raw;
	logic [2:0]        motion_in;
	logic [BEMF_W-1:0] bemf_meas, bemf_ref;
	logic [31:0]       seed;
	int                n_mismatch, checks_done, cyc, m, rf, ms, bw, fl, ex;
	int                sp[4] = '{32'h3FF, 32'h400, 32'h401, 32'h400};

	mdf_flag_bank mdf_flag_bank_inst (
		.clk, .rst_b, .ce, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .cond_raw, .motion_in, .thermal_in, .bemf_meas,
		.bemf_ref, .elec_summary, .safe_target_valid, .irq);

	mdf_axi_master mdf_axi_master_inst (
		.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);

	// Clock, and the guard that ends a hung run
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Flags that conditions set, in the full-read-A snapshot layout
	function automatic int setv(input logic [COND_W-1:0] v);
		return int'({v[8], |v[8:4], 3'h0, v[7], v[6], v[0], 2'h0, v[2],
			v[1], v[3], 1'h0});
	endfunction

	function automatic int es_of(input int f);
		return (f >> 13 | f >> 12 | f >> 1 | f) & 1;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d);
		logic [1:0] r;
		mdf_axi_master_inst.wr(a, d, 4'hF, r);
		chk(32'(r), 32'(a > OFF_BEMF_CFG ? RESP_SLVERR : RESP_OKAY));
	endtask

	task automatic rd(input logic [AXI_AW-1:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		mdf_axi_master_inst.rd(a, d, r);
		chk(d, e);
		chk(32'(r), 32'(a > OFF_BEMF_CFG ? RESP_SLVERR : RESP_OKAY));
	endtask

	// Full read A: snapshot before the clear, set beats clear
	task automatic full_a();
		int e;
		e = m | int'(motion_in) << 9 | int'(thermal_in) << 4;
		m = setv(cond_raw) | (thermal_in != 2'h0 ? m & 32'hC : 0);
		wr(OFF_CMD, 32'h1);
		rd(OFF_RESP_A, 32'(e));
	endtask

	task automatic report_and_stop();
		if (n_mismatch == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence
	initial begin
		{clk, rst_b, ce, cond_raw, motion_in, thermal_in} = 17'h04000;
		{bemf_meas, bemf_ref} = 16'h8080;
		seed = 32'hC1BB1518;
		m = 32'h41;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk(32'(safe_target_valid), 32'h0);
		chk(32'(irq), 32'h0);
		rd(OFF_IRQ_MASK, 32'h0);
		rd(OFF_SAFE_POS, 32'(SAFE_RESERVED));
		rd(OFF_LIVE, 32'h9020);
		for (int i = 0; i < 8; i++) begin
			motion_in <= 3'(i);
			thermal_in <= 2'(i);
			tick(3);
			wr(OFF_CMD, 32'h8);
			rd(OFF_RESP_S, 32'(32'h60 | i << 2 | i & 3));
		end
		wr(OFF_CMD, 32'h4);
		rd(OFF_RESP_S, 32'h7F);
		wr(OFF_CMD, 32'h8);
		rd(OFF_RESP_S, 32'h1F);
		m = 32'h40;
		// Random faults, some still present while the clear acts
		for (int i = 0; i < 12; i++) begin
			cond_raw <= i[0] ? COND_W'(rnd()) : '0;
			thermal_in <= 2'(rnd());
			tick(5);
			m |= setv(cond_raw);
			full_a();
			@(negedge clk);
			chk(32'(elec_summary), 32'(es_of(m)));
		end
		// Back-EMF against band and floor
		for (int i = 0; i < 12; i++) begin
			bw = int'(rnd() % 16);
			fl = int'(rnd() % 16);
			rf = int'(rnd() % 32);
			ms = rf + int'(rnd() % 33) - 16;
			if (ms < 0)
				ms = 0;
			ex = (ms > rf + bw) << 2 | (ms < rf - bw) << 1 | (ms < fl);
			bemf_ref <= 8'(rf);
			bemf_meas <= 8'(ms);
			wr(OFF_BEMF_CFG, 32'(bw << 8 | fl));
			tick(3);
			wr(OFF_CMD, 32'h2);
			rd(OFF_RESP_B, 32'(ex));
		end
		foreach (sp[k]) begin
			wr(OFF_SAFE_POS, 32'(sp[k]));
			tick(3);
			@(negedge clk);
			chk(32'(safe_target_valid), 32'(sp[k] != 32'h400));
		end
		// Interrupt: sticky status, mask, level output, write-one clear
		{bemf_meas, bemf_ref} <= 16'h8080;
		{cond_raw, thermal_in} <= '0;
		tick(5);
		full_a();
		wr(OFF_IRQ_STAT, 32'h1FF);
		rd(OFF_IRQ_STAT, 32'h0);
		cond_raw <= 9'h100;
		tick(5);
		m |= setv(cond_raw);
		rd(OFF_IRQ_STAT, 32'h180);
		wr(OFF_IRQ_MASK, 32'h100);
		rd(OFF_IRQ_MASK, 32'h100);
		cond_raw <= '0;
		tick(5);
		@(negedge clk);
		chk(32'(irq), 32'h1);
		full_a();
		wr(OFF_IRQ_STAT, 32'h180);
		tick(2);
		@(negedge clk);
		chk(32'(irq), 32'h0);
		rd(OFF_IRQ_STAT, 32'h0);
		wr(8'h3C, 32'hFFFFFFFF);
		rd(8'h3C, 32'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
